// >>> hdl/icso_port.sv
// Serial output port, internal SCK, 3-wire continuous conversion mode
//
// Summary of operation
// - SCK level at reset end picks clock mode
// - Works with chip select tied low forever
// - Converting: SCK and SDO both held high
// - Conversion done: SCK, SDO low, enter sleep
// - Sleep half SCK period, then shift unprompted
// - Transfer spans first to 32nd rising edge
// - Capture SDI on every rising SCK edge
// - Update SDO on each falling SCK edge
// - Drive generated SCK out on the pin
// - After 32nd rise: SDO high, SCK high
// - Sampling tick 123kHz or 2.5 oscillator cycles
// - EOC fall loads result into shift register
`timescale 1ns/1ps
module icso_port (
  input  wire logic                       CLOCK,
  input  wire logic                       SRST,
  input  wire logic                       CS_N,
  input  wire logic                       SDI,
  input  wire logic                       SCK_I,
  output logic                            SCK_O,
  output logic                            SCK_OE,
  output logic                            SDO,
  input  wire logic                       OSCILLATOR_REJECTION_SELECT_PIN,
  input  wire icso_pkg::icso_word_s       RESULT,
  input  wire logic                       RESULT_VALID,
  output logic                            RESULT_READY,
  output logic                            CONV_START,
  output icso_pkg::icso_word_s            CFG,
  output logic                            CFG_STROBE,
  output logic                            SAMPLE_TICK,
  output logic                            EXT_OSC
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s1, sck_s2;        // SCK pin level
  logic sdi_s1, sdi_s2;        // Serial config input
  logic osc_s1, osc_s2, osc_s3; // Oscillator pin, third stage for edges
  logic cs_s1,  cs_s2;         // Select, synced but not needed here

  // Two stages per pin, three for the oscillator; SCK stages reset to the pull-up level
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      cs_s1  <= 1'b0;
      cs_s2  <= 1'b0;
    end else begin
      sck_s1 <= SCK_I;
      sck_s2 <= sck_s1;
      sdi_s1 <= SDI;
      sdi_s2 <= sdi_s1;
      osc_s1 <= OSCILLATOR_REJECTION_SELECT_PIN;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      cs_s1  <= CS_N;
      cs_s2  <= cs_s1;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  icso_pkg::icso_word_s buf_out;   // Oldest buffered result
  logic                 buf_valid; // A finished conversion is waiting
  logic                 buf_pop;   // Load into shift register

  icso_fifo #(
    .W     (icso_pkg::WORD_W),
    .DEPTH (icso_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (CLOCK),
    .srst      (SRST),
    .in_valid  (RESULT_VALID),
    .in_data   (RESULT.data),
    .in_ready  (RESULT_READY),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out.data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  icso_pkg::icso_state_e state;    // Port state
  logic [7:0]            tmr;      // Strap, sleep and half-period timer
  logic [5:0]            rises;    // Rising edges made this transfer
  logic [icso_pkg::WORD_W-1:0] sreg;   // Static output shift register
  logic [icso_pkg::WORD_W-1:0] cfg_sh; // Config bits shifted in
  logic                  tick;     // Timer reached its end

  assign buf_pop = (state == icso_pkg::ST_CONVERT) && buf_valid;
  assign tick    = (state == icso_pkg::ST_SLEEP)
                   ? (tmr == icso_pkg::SLEEP_CYC - 8'h01)
                   : (tmr == icso_pkg::SCK_HALF_CYC - 8'h01);

  // State, pins and shifting; select input is ignored
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state      <= icso_pkg::ST_STRAP;
      tmr        <= 8'h00;
      rises      <= 6'h00;
      sreg       <= '0;
      cfg_sh     <= '0;
      SCK_O      <= 1'b1;
      SCK_OE     <= 1'b0;
      SDO        <= 1'b1;
      CONV_START <= 1'b0;
      CFG        <= '0;
      CFG_STROBE <= 1'b0;
    end else begin
      CONV_START <= 1'b0;
      CFG_STROBE <= 1'b0;
      unique case (state)
        icso_pkg::ST_STRAP: begin
          // Strap caught after reset release
          tmr <= tmr + 8'h01;
          if (tmr == icso_pkg::STRAP_WAIT) begin
            tmr <= 8'h00;
            if (sck_s2) begin
              state      <= icso_pkg::ST_CONVERT;
              SCK_OE     <= 1'b1;
              CONV_START <= 1'b1;
            end else begin
              state <= icso_pkg::ST_EXT;
            end
          end
        end
        icso_pkg::ST_EXT: begin
          // External clock mode: port left released
          SCK_OE <= 1'b0;
        end
        icso_pkg::ST_CONVERT: begin
          // Both lines high while converting
          SCK_O <= 1'b1;
          SDO   <= 1'b1;
          if (buf_valid) begin
            // EOC falls, result loaded, sleep entered
            sreg  <= {1'b0, buf_out.data[icso_pkg::EOC_BIT-1:0]};
            SCK_O <= 1'b0;
            SDO   <= 1'b0;
            tmr   <= 8'h00;
            state <= icso_pkg::ST_SLEEP;
          end
        end
        icso_pkg::ST_SLEEP: begin
          // Minimum sleep, then start unprompted
          tmr <= tmr + 8'h01;
          if (tick) begin
            tmr   <= 8'h00;
            rises <= 6'h00;
            state <= icso_pkg::ST_SHIFT;
          end
        end
        icso_pkg::ST_SHIFT: begin
          tmr <= tmr + 8'h01;
          if (tick) begin
            tmr <= 8'h00;
            if (!SCK_O) begin
              // Rising edge: capture SDI
              SCK_O  <= 1'b1;
              cfg_sh <= {cfg_sh[icso_pkg::WORD_W-2:0], sdi_s2};
              rises  <= rises + 6'h01;
              if (rises == icso_pkg::XFER_BITS - 6'h01) begin
                // 32nd rise ends the transfer
                SDO        <= 1'b1;
                state      <= icso_pkg::ST_CONVERT;
                CONV_START <= 1'b1;
                CFG.data   <= {cfg_sh[icso_pkg::WORD_W-2:0], sdi_s2};
                CFG_STROBE <= 1'b1;
              end
            end else begin
              // Falling edge: next result bit
              SCK_O <= 1'b0;
              SDO   <= sreg[icso_pkg::EOC_BIT-1];
              sreg  <= {sreg[icso_pkg::WORD_W-2:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sampling clock enable
  // ----------------------------------------------------------------
  logic [7:0] samp_cnt;  // Internal period counter
  logic [7:0] edge_cnt;  // Oscillator edges since last tick
  logic [7:0] idle_cnt;  // Cycles since last oscillator edge
  logic       osc_edge;  // Either edge of the oscillator pin

  assign osc_edge = osc_s2 ^ osc_s3;

  // Oscillator presence detection
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      idle_cnt <= 8'h00;
      EXT_OSC  <= 1'b0;
    end else if (osc_edge) begin
      idle_cnt <= 8'h00;
      EXT_OSC  <= 1'b1;
    end else if (idle_cnt == icso_pkg::OSC_IDLE_CYC) begin
      EXT_OSC  <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // Tick at 123kHz, or every 2.5 oscillator periods
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      samp_cnt    <= 8'h00;
      edge_cnt    <= 8'h00;
      SAMPLE_TICK <= 1'b0;
    end else if (EXT_OSC) begin
      samp_cnt    <= 8'h00;
      SAMPLE_TICK <= 1'b0;
      if (osc_edge) begin
        if (edge_cnt == icso_pkg::EXT_SAMP_EDGES - 8'h01) begin
          edge_cnt    <= 8'h00;
          SAMPLE_TICK <= 1'b1;
        end else begin
          edge_cnt <= edge_cnt + 8'h01;
        end
      end
    end else begin
      edge_cnt    <= 8'h00;
      SAMPLE_TICK <= samp_cnt == icso_pkg::SAMP_CYC - 8'h01;
      samp_cnt    <= (samp_cnt == icso_pkg::SAMP_CYC - 8'h01)
                     ? 8'h00 : samp_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  logic [icso_pkg::WORD_W-1:0] buf_q;  // Buffer head one cycle back
  always_ff @(posedge CLOCK) begin
    buf_q <= buf_out.data;
  end

  convert_hold_a: assert property (
    state == icso_pkg::ST_CONVERT && $past(state) == icso_pkg::ST_CONVERT
    |-> SCK_O && SDO)
    else $error("Lines not high while converting");
  eoc_fall_a: assert property (
    state == icso_pkg::ST_CONVERT && buf_valid
    |=> state == icso_pkg::ST_SLEEP && !SCK_O && !SDO)
    else $error("End of conversion not shown low");
  sleep_min_a: assert property (
    $rose(state == icso_pkg::ST_SLEEP)
    |-> (state == icso_pkg::ST_SLEEP && !SCK_O)[*4]
    ##1 state == icso_pkg::ST_SHIFT)
    else $error("Sleep length wrong");
  rise_count_a: assert property (
    $fell(state == icso_pkg::ST_SHIFT) |-> rises == 6'h20)
    else $error("Transfer did not end on 32nd rise");
  sdi_capture_a: assert property (
    state == icso_pkg::ST_SHIFT && $rose(SCK_O)
    |-> cfg_sh[0] == $past(sdi_s2))
    else $error("SDI not captured on rising edge");
  sdo_on_fall_a: assert property (
    state == icso_pkg::ST_SHIFT && $past(state) == icso_pkg::ST_SHIFT
    && $changed(SDO) |-> $fell(SCK_O))
    else $error("SDO moved away from falling edge");
  sck_drive_a: assert property (
    state inside {icso_pkg::ST_CONVERT, icso_pkg::ST_SLEEP,
                  icso_pkg::ST_SHIFT} |-> SCK_OE)
    else $error("Generated SCK not driven");
  ext_mode_a: assert property (
    state == icso_pkg::ST_EXT |-> ##1 !SCK_OE ##1 state == icso_pkg::ST_EXT)
    else $error("External mode drives SCK");
  new_conv_a: assert property (
    $fell(state == icso_pkg::ST_SHIFT)
    |-> SDO && SCK_O && CFG_STROBE && CONV_START)
    else $error("New conversion not flagged");
  samp_period_a: assert property (
    SAMPLE_TICK && !EXT_OSC && !$past(EXT_OSC) |=> !SAMPLE_TICK[*8])
    else $error("Internal sampling tick too fast");
  load_a: assert property (
    $rose(state == icso_pkg::ST_SLEEP)
    |-> sreg[icso_pkg::EOC_BIT-1:0] == buf_q[icso_pkg::EOC_BIT-1:0])
    else $error("Result not loaded at EOC fall");

  xfer_c: cover property ($fell(state == icso_pkg::ST_SHIFT));
  buf_full_c: cover property (!RESULT_READY && state == icso_pkg::ST_SHIFT);
  ext_osc_c: cover property (EXT_OSC && SAMPLE_TICK);
  ext_mode_c: cover property (state == icso_pkg::ST_EXT);
  // Select seen low in a cycle while a transfer is shifting
  cs_low_c: cover property (!cs_s2 && state == icso_pkg::ST_SHIFT);

endmodule

// >>> pkg/icso_pkg.sv
// Constants, states and carriers of the internal-clock continuous serial port
package icso_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;  // System clock rate
  localparam int CLK_NS      = 50;          // System clock period
  localparam int SCK_HALF_NS = 200;         // Half of generated SCK period
  // Half SCK period in cycles, a least time rounded up
  localparam logic [7:0] SCK_HALF_CYC =
    8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
  // Least time spent asleep: half an SCK period
  localparam logic [7:0] SLEEP_CYC = SCK_HALF_CYC;
  localparam int SAMP_HZ     = 123_000;     // Internal sampling clock
  // Sampling period in cycles, rounded down
  localparam logic [7:0] SAMP_CYC  = 8'(CLK_HZ / SAMP_HZ);
  // 2.5 external periods is five oscillator edges
  localparam logic [7:0] EXT_SAMP_EDGES = 8'h05;
  // Cycles without an oscillator edge before falling back to internal
  localparam logic [7:0] OSC_IDLE_CYC   = 8'h40;
  // Cycles after reset release before the SCK strap is caught
  localparam logic [7:0] STRAP_WAIT     = 8'h03;

  // ----------------------------------------------------------------
  // Transfer shape
  // ----------------------------------------------------------------
  localparam int         WORD_W    = 32;     // Result and config width
  localparam logic [5:0] XFER_BITS = 6'h20;  // Rising edges per transfer
  localparam int         BUF_DEPTH = 2;      // Result buffer entries
  localparam int         EOC_BIT   = 31;     // Position of the EOC flag

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP,    // Waiting to catch the SCK strap
    ST_EXT,      // External clock mode, port stays released
    ST_CONVERT,  // Conversion running, SCK and SDO high
    ST_SLEEP,    // Result loaded, SCK and SDO low
    ST_SHIFT     // Generating the 32 SCK pulses
  } icso_state_e;

  typedef struct packed {
    logic [WORD_W-1:0] data;  // Conversion result bits
  } icso_word_s;

endpackage

// >>> hdl/icso_fifo.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module icso_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];  // Entry storage
  logic [PW-1:0] wr_ptr;       // Next slot to fill
  logic [PW-1:0] rd_ptr;       // Oldest slot
  logic [CW-1:0] count;        // Entries held
  logic [CW-1:0] next_count;   // Count after this cycle
  logic          push;         // Word accepted
  logic          pop;          // Word drained

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data   = mem[rd_ptr];

  // Write side
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
    end else if (push) begin
      mem[wr_ptr] <= in_data;
      wr_ptr      <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
  end

  // Read side
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
  end

  // Fill level and registered flags
  always_ff @(posedge clk) begin
    if (srst) begin
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule

// >>> verification/icso_host.sv
// Host receiver model driven by the generated serial clock
`timescale 1ns/1ps
module icso_host (
  input  wire logic        clk,
  input  wire logic        sck,
  input  wire logic        sdo,
  input  wire logic [31:0] cfg_word,
  output logic             sdi,
  output logic [31:0]      rx_word,
  output logic [7:0]       frames
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        sck_q;  // Clock level one cycle back
  logic        sdo_q;  // Data level just before the edge
  logic [31:0] shreg;  // Bits received, first at MSB
  logic [5:0]  rises;  // Rising edges in this frame

  initial begin
    sck_q   = 1'b1;
    sdo_q   = 1'b1;
    shreg   = 32'h0;
    rises   = 6'h00;
    frames  = 8'h00;
    rx_word = 32'h0;
    sdi     = 1'b0;
  end

  // ----------------------------------------------------------------
  // Edge tracking, capture on rise, next config bit on fall
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    sck_q <= sck;
    sdo_q <= sdo;
    if (sck && !sck_q) begin
      // Data taken as it stood just before the rise
      shreg <= {shreg[30:0], sdo_q};
      rises <= rises + 6'h01;
      if (rises == 6'h1F) begin
        rx_word <= {shreg[30:0], sdo_q};
        frames  <= frames + 8'h01;
        rises   <= 6'h00;
        // Released line shows the inverse of its last level
        sdi     <= ~sdi;
      end
    end else if (!sck && sck_q) begin
      sdi <= cfg_word[5'h1F - rises[4:0]];
    end
  end
endmodule

// >>> verification/internal_clock_continuous_serial_out_tb.sv
// Self-checking bench for the internal-clock continuous serial port
`timescale 1ns/1ps
module internal_clock_continuous_serial_out_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int        LIMIT = 6000;   // Cycle ceiling of the run
  logic                 clock = 1'b0;   // System clock
  logic                 srst = 1'b1;    // Reset
  logic                 sck_low = 1'b0; // Board pulls SCK low
  logic                 osc = 1'b0;     // Oscillator pin
  logic                 osc_on = 1'b0;  // Oscillator running
  logic [1:0]           div = 2'h0;     // Oscillator divider
  logic                 valid = 1'b0;   // Result offered
  icso_pkg::icso_word_s result = '0;    // Result word
  icso_pkg::icso_word_s cfg_out;        // Config seen by the port
  logic [31:0]          cfg_word = '0;  // Config sent by host
  logic [31:0]          rx_word;        // Last word received
  logic [7:0]           frames;         // Frames received
  logic [7:0]           frames_q = '0;  // Frames one cycle back
  logic [31:0]          rxq[$];         // Words in arrival order
  logic                 sck_o, sck_oe, sdo, sdi, ready, sck_w;
  logic                 conv_start, cfg_strobe, tick, ext_osc;
  int                   fails = 0;      // Mismatches
  int                   checked = 0;    // Comparisons
  int                   cyc = 0;        // Cycles run

  // Pin level: driver, else board low, else weak pull-up
  assign sck_w = sck_oe ? sck_o : !sck_low;

  always #25 clock = ~clock;

  icso_port dut (
    .CLOCK(clock), .SRST(srst), .CS_N(1'b0), .SDI(sdi), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE(sck_oe), .SDO(sdo),
    .OSCILLATOR_REJECTION_SELECT_PIN(osc), .RESULT(result),
    .RESULT_VALID(valid), .RESULT_READY(ready), .CONV_START(conv_start),
    .CFG(cfg_out), .CFG_STROBE(cfg_strobe), .SAMPLE_TICK(tick),
    .EXT_OSC(ext_osc)
  );

  icso_host host (
    .clk(clock), .sck(sck_w), .sdo(sdo), .cfg_word(cfg_word),
    .sdi(sdi), .rx_word(rx_word), .frames(frames)
  );

  // Collect words as the host finishes frames
  always @(posedge clock) begin
    frames_q <= frames;
    if (frames != frames_q) begin
      rxq.push_back(rx_word);
    end
  end

  // Oscillator: an edge every third cycle
  always @(posedge clock) begin
    #1;
    if (osc_on) begin
      div = (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h0) begin
        osc = ~osc;
      end
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Offer a word and hold it until taken; caller drops valid
  task automatic push(input logic [31:0] w);
    result.data = w;
    valid = 1'b1;
    while (ready !== 1'b1) step(1);
    step(1);
  endtask

  // Cycles between two sampling ticks
  task automatic gap(output int n);
    while (tick !== 1'b1) step(1);
    step(1);
    n = 1;
    while (tick !== 1'b1) begin
      n++;
      step(1);
    end
  endtask

  task automatic summarize();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_strap();
    int n;
    n = 0;
    repeat (10) begin
      if (conv_start === 1'b1) n++;
      step(1);
    end
    chk(32'(n), 32'h1);
    chk(32'(sck_oe), 32'h1);
  endtask

  task automatic t_idle();
    int bad;
    bad = 0;
    repeat (40) begin
      if ({sck_o, sdo} !== 2'b11) bad++;
      step(1);
    end
    chk(32'(bad), 32'h0);
  endtask

  task automatic t_frame(input logic [31:0] w, input logic [31:0] cfg);
    int   lo;
    logic seen;
    lo = 0;
    seen = 1'b0;
    cfg_word = cfg;
    push(w);
    valid = 1'b0;
    step(1);
    chk(32'({sck_o, sdo}), 32'h0);
    while (sck_o === 1'b0 && lo < 20) begin
      lo++;
      step(1);
    end
    chk(32'(lo), 32'(icso_pkg::SCK_HALF_CYC) * 32'h2);
    while (rxq.size() == 0) begin
      if (cfg_strobe === 1'b1) seen = 1'b1;
      step(1);
    end
    chk(rxq.pop_front(), {1'b0, w[30:0]});
    chk(32'(seen), 32'h1);
    chk(cfg_out.data, cfg);
    chk(32'({sck_o, sdo}), 32'h3);
  endtask

  // Fill the buffer until it refuses, then drain in order
  task automatic t_buffer();
    push(32'h1111_1111);
    push(32'h2222_2222);
    push(32'h3333_3333);
    valid = 1'b0;
    step(1);
    chk(32'(ready), 32'h0);
    push(32'h4444_4444);
    valid = 1'b0;
    while (rxq.size() < 4) step(1);
    for (int i = 1; i <= 4; i++) begin
      chk(rxq.pop_front(), 32'h1111_1111 * 32'(i));
    end
  endtask

  task automatic t_ticks();
    int n;
    gap(n);
    chk(32'(n), 32'(icso_pkg::SAMP_CYC));
    osc_on = 1'b1;
    step(20);
    gap(n);
    gap(n);
    chk(32'(ext_osc), 32'h1);
    chk(32'(n), 32'(icso_pkg::EXT_SAMP_EDGES) * 32'h3);
    osc_on = 1'b0;
    step(100);
    chk(32'(ext_osc), 32'h0);
    gap(n);
    chk(32'(n), 32'(icso_pkg::SAMP_CYC));
  endtask

  // Second reset with SCK held low selects external mode
  task automatic t_ext();
    int n;
    n = 0;
    sck_low = 1'b1;
    srst = 1'b1;
    step(16);
    srst = 1'b0;
    repeat (40) begin
      if (conv_start !== 1'b0 || sck_oe !== 1'b0) n++;
      step(1);
    end
    chk(32'(n), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(16);
    srst = 1'b0;
    t_strap();
    t_idle();
    t_frame(32'h9ABC_DEF0, 32'hC3A5_0F81);
    t_buffer();
    t_ticks();
    t_ext();
    summarize();
  end
endmodule
